// ===== include/spis_regs.vh
// Register offsets, field positions and reset values for the port interrupt status block
`ifndef SPIS_REGS_VH
`define SPIS_REGS_VH

// Byte offsets of the registers on the APB
`define SPIS_SERR_OFFSET      12'h000
`define SPIS_ISR_OFFSET       12'h004
`define SPIS_IMR_OFFSET       12'h008

// Port serial error register bit positions
`define SPIS_SERR_PHYRDY_BIT  1
`define SPIS_SERR_UNFIS_BIT   10
`define SPIS_SERR_FIFO_BIT    11
`define SPIS_SERR_CRC_BIT     21
`define SPIS_SERR_RERR_BIT    22

// Interrupt status bit positions
`define SPIS_ISR_PHYRDY_BIT   17
`define SPIS_ISR_FIFO_BIT     18
`define SPIS_ISR_RERR_BIT     19
`define SPIS_ISR_UNFIS_BIT    20
`define SPIS_ISR_INTEG_BIT    21
`define SPIS_ISR_CRC_BIT      22

// Implemented bits of each register
`define SPIS_SERR_MASK        32'h0060_0C02
`define SPIS_ISR_MASK         32'h007E_0000

// Reset values
`define SPIS_SERR_RESET       32'h0000_0000
`define SPIS_IMR_RESET        32'h0000_0000
`define SPIS_ZERO_WORD        32'h0000_0000

`endif

// ===== hw/spis_port_int_status.v
// Per-port serial error latch, interrupt status mirror and mask with APB access
//
// Notes on behaviour
// - Status bit 22 follows serial error bit 21 (earlier CRC error) and clears on writing 1 there.
// - Status bit 21 is set by a host CRC or disparity error or by an R_ERR answer to a Data FIS.
// - Status bit 20 follows serial error bit 10 (unsupported FIS) and clears on writing 1 there.
// - Status bit 19 follows serial error bit 22 (R_ERR in a Data FIS) and clears on writing 1 there.
// - Status bit 18 follows serial error bit 11 (FIFO error) and clears on writing 1 there.
// - Status bit 17 follows serial error bit 1 (PHY not ready to ready) and clears on writing 1 there.
// - The PHY ready status bit reads zero after reset since the PHY is not ready yet.
// - The PHY ready status bit goes to one once the PHY reaches ready during link bring-up.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "spis_regs.vh"

module spis_port_int_status (
	// APB clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output wire [31:0] prdata,
	// Link and transport event pulses, same clock domain
	input  wire        crc_err_evt,
	input  wire        disparity_err_evt,
	input  wire        rerr_prim_evt,
	input  wire        unrec_fis_evt,
	input  wire        fifo_err_evt,
	// PHY ready level, same clock domain
	input  wire        phy_ready,
	// Interrupt
	output wire        irq
);

	reg  [31:0] port_serial_error_reg;
	reg  [31:0] port_serial_error_next;
	reg  [31:0] imr_reg;
	reg  [31:0] prdata_reg;
	reg         pslverr_reg;
	reg         phy_ready_reg;
	reg  [31:0] set_vec;
	reg  [31:0] rd_word;
	reg         rd_hit;
	wire [31:0] isr_word;
	wire        setup_ph;
	wire        access_ph;
	wire        wr_serr;
	wire        wr_imr;
	wire        crc_error_diag_flag;
	wire        handshake_error_diag_flag;

	// Decode a register offset against the bus address
	function addr_is;
		input [11:0] a;
		input [11:0] off;
		begin
			addr_is = (a[11:2] == off[11:2]);
		end
	endfunction

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	// Zero wait states: read data is captured in the setup cycle
	assign pready    = 1'b1;
	assign pslverr   = pslverr_reg;
	assign prdata    = prdata_reg;
	assign wr_serr   = access_ph & pwrite & addr_is(paddr, `SPIS_SERR_OFFSET);
	assign wr_imr    = access_ph & pwrite & addr_is(paddr, `SPIS_IMR_OFFSET);

	// Host-detected CRC or disparity both land in the CRC diag flag
	always @* begin
		set_vec = `SPIS_ZERO_WORD;
		set_vec[`SPIS_SERR_CRC_BIT]    = crc_err_evt | disparity_err_evt;
		set_vec[`SPIS_SERR_RERR_BIT]   = rerr_prim_evt;
		set_vec[`SPIS_SERR_UNFIS_BIT]  = unrec_fis_evt;
		set_vec[`SPIS_SERR_FIFO_BIT]   = fifo_err_evt;
		set_vec[`SPIS_SERR_PHYRDY_BIT] = phy_ready & ~phy_ready_reg;
	end

	// Sticky bits; a new event wins over a write-one clear in the same cycle
	always @* begin
		port_serial_error_next = port_serial_error_reg;
		if (wr_serr) begin
			port_serial_error_next = port_serial_error_reg & ~pwdata;
		end
		port_serial_error_next = (port_serial_error_next | set_vec) & `SPIS_SERR_MASK;
	end

	// Error latch, mask and PHY edge history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_serial_error_reg <= `SPIS_SERR_RESET;
			imr_reg               <= `SPIS_IMR_RESET;
			phy_ready_reg         <= 1'b0;
		end else begin
			port_serial_error_reg <= port_serial_error_next;
			phy_ready_reg         <= phy_ready;
			if (wr_imr) begin
				imr_reg <= pwdata & `SPIS_ISR_MASK;
			end
		end
	end

	assign crc_error_diag_flag       = port_serial_error_reg[`SPIS_SERR_CRC_BIT];
	assign handshake_error_diag_flag = port_serial_error_reg[`SPIS_SERR_RERR_BIT];

	// Status is pure wiring; only a write-one clear of the serial error register clears it
	assign isr_word[31:23] = 9'h000;
	assign isr_word[22]    = crc_error_diag_flag;
	assign isr_word[21]    = crc_error_diag_flag | handshake_error_diag_flag;
	assign isr_word[20]    = port_serial_error_reg[`SPIS_SERR_UNFIS_BIT];
	assign isr_word[19]    = handshake_error_diag_flag;
	assign isr_word[18]    = port_serial_error_reg[`SPIS_SERR_FIFO_BIT];
	assign isr_word[17]    = port_serial_error_reg[`SPIS_SERR_PHYRDY_BIT];
	assign isr_word[16:0]  = 17'h0_0000;

	assign irq = |(isr_word & imr_reg);

	// Read mux; unmapped offsets read zero and flag an error
	always @* begin
		rd_word = `SPIS_ZERO_WORD;
		rd_hit  = 1'b1;
		if (addr_is(paddr, `SPIS_SERR_OFFSET)) begin
			rd_word = port_serial_error_reg;
		end else if (addr_is(paddr, `SPIS_ISR_OFFSET)) begin
			rd_word = isr_word;
		end else if (addr_is(paddr, `SPIS_IMR_OFFSET)) begin
			rd_word = imr_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Bus answer registers, loaded in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= `SPIS_ZERO_WORD;
			pslverr_reg <= 1'b0;
		end else if (setup_ph) begin
			prdata_reg  <= pwrite ? `SPIS_ZERO_WORD : rd_word;
			pslverr_reg <= ~rd_hit;
		end else if (!psel) begin
			pslverr_reg <= 1'b0;
		end
	end

endmodule // spis_port_int_status

// ===== testbench/spis_sata_dev.sv
// Link partner model driving error event pulses and the PHY ready level
`timescale 1ns/1ps
module spis_sata_dev (
	// Clock
	input  wire       pclk,
	// Event pulses: crc, disparity, rerr, unrecognised fis, fifo
	output reg  [4:0] evt,
	output reg        phy_ready
);
	// One cycle pulse, released at the next edge
	task pulse(input integer i);
		begin
			evt[i] <= 1'b1;
			@(posedge pclk);
			evt <= 5'h0;
		end
	endtask
	// Link bring-up or loss, held as a level
	task link(input logic v);
		begin
			phy_ready <= v;
			@(posedge pclk);
		end
	endtask
	// Quiet link at time zero
	initial evt = 5'h0;
	initial phy_ready = 1'b0;
endmodule // spis_sata_dev

// ===== testbench/spis_chk.sv
// Concurrent checks on the port interrupt status block
`timescale 1ns/1ps
module spis_chk (
	// APB side
	input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	// Event side and interrupt
	input wire        crc_err_evt, disparity_err_evt, rerr_prim_evt, unrec_fis_evt,
	input wire        fifo_err_evt, phy_ready, irq
);
	// Status read in its setup cycle
	wire rd = psel && !penable && !pwrite && paddr == 12'h004;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_crc_mirror: assert property (rd && $past(crc_err_evt) |=> prdata[22])
		else $error("crc status bit missing");
	chk_integ_sources: assert property (rd && $past(crc_err_evt || disparity_err_evt
		|| rerr_prim_evt) |=> prdata[21]) else $error("integrity bit missing");
	chk_unfis_mirror: assert property (rd && $past(unrec_fis_evt) |=> prdata[20])
		else $error("unrecognised fis bit missing");
	chk_rerr_mirror: assert property (rd && $past(rerr_prim_evt) |=> prdata[19])
		else $error("rerr bit missing");
	chk_fifo_mirror: assert property (rd && $past(fifo_err_evt) |=> prdata[18])
		else $error("fifo bit missing");
	chk_phy_rise: assert property (rd && $past(phy_ready) && !$past(phy_ready, 2)
		|=> prdata[17]) else $error("phy ready bit missing");
	chk_reset_clean: assert property ($rose(presetn) |-> prdata == 32'h0000_0000 && !irq)
		else $error("not clean after reset");
	chk_status_bits: assert property (rd |=> (prdata & 32'hFF81_FFFF) == 32'h0000_0000)
		else $error("status bit outside field");
	// Main scenarios reached
	cover property (rd && $past(phy_ready));
	cover property (irq);
	cover property (psel && penable && pslverr);
endmodule // spis_chk
bind spis_port_int_status spis_chk i_spis_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .crc_err_evt(crc_err_evt),
	.disparity_err_evt(disparity_err_evt), .rerr_prim_evt(rerr_prim_evt),
	.unrec_fis_evt(unrec_fis_evt), .fifo_err_evt(fifo_err_evt), .phy_ready(phy_ready),
	.irq(irq));

// ===== testbench/spis_port_int_status_tb.sv
// Self-checking bench for the port interrupt status block
`timescale 1ns/1ps
module spis_port_int_status_tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, irq, phy_ready, err;
	logic [4:0]  evt;
	integer      fails = 0, n_compared = 0, i;
	localparam logic [31:0] zero = 32'h0000_0000, one = 32'h0000_0001;
	// Status seen and clearing word for each event source
	logic [31:0] isr_exp [5] = '{32'h0060_0000, 32'h0060_0000, 32'h0028_0000,
		32'h0010_0000, 32'h0004_0000};
	logic [31:0] serr_clr [5] = '{32'h0020_0000, 32'h0020_0000, 32'h0040_0000,
		32'h0000_0400, 32'h0000_0800};
	always #5 pclk = ~pclk;
	spis_sata_dev i_spis_sata_dev (.pclk(pclk), .evt(evt), .phy_ready(phy_ready));
	spis_port_int_status i_spis_port_int_status (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .crc_err_evt(evt[0]),
		.disparity_err_evt(evt[1]), .rerr_prim_evt(evt[2]), .unrec_fis_evt(evt[3]),
		.fifo_err_evt(evt[4]), .phy_ready(phy_ready), .irq(irq));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_compared++;
			if (seen !== exp) begin
				fails++;
				$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	// One APB transfer and an idle cycle, entered just after an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, e);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			err = pslverr;
			chk(prdata, e);
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 12'h004, zero, zero);
		chk({31'h0, err}, zero);
		xfer(1'b0, 12'h000, zero, zero);
		chk({31'h0, irq}, zero);
		xfer(1'b1, 12'h008, 32'hFFFF_FFFF, zero);
		xfer(1'b0, 12'h008, zero, 32'h007E_0000);
		xfer(1'b1, 12'h008, 32'h007E_0000, zero);
		$display("reset and mask tests done");
		for (i = 0; i < 5; i++) begin
			i_spis_sata_dev.pulse(i);
			xfer(1'b0, 12'h004, zero, isr_exp[i]);
			xfer(1'b0, 12'h000, zero, serr_clr[i]);
			chk({31'h0, irq}, one);
			xfer(1'b1, 12'h004, 32'hFFFF_FFFF, zero);
			xfer(1'b0, 12'h004, zero, isr_exp[i]);
			xfer(1'b1, 12'h000, serr_clr[i], zero);
			xfer(1'b0, 12'h004, zero, zero);
			chk({31'h0, irq}, zero);
		end
		$display("event tests done");
		i_spis_sata_dev.link(1'b1);
		xfer(1'b0, 12'h004, zero, 32'h0002_0000);
		chk({31'h0, irq}, one);
		xfer(1'b0, 12'h000, zero, 32'h0000_0002);
		xfer(1'b1, 12'h008, zero, zero);
		chk({31'h0, irq}, zero);
		xfer(1'b1, 12'h000, 32'h0000_0002, zero);
		xfer(1'b0, 12'h004, zero, zero);
		xfer(1'b0, 12'h0FC, zero, zero);
		chk({31'h0, err}, one);
		$display("phy and unmapped tests done");
		summarize;
	end
	// Hang guard, far beyond the about 134 cycles of the run
	initial begin
		#20000;
		fails++;
		summarize;
	end
endmodule // spis_port_int_status_tb
